/* design/rgbfc_regs.svh */
`ifndef RGBFC_REGS_SVH
`define RGBFC_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RGBFC_ADDR_ID        8'h00
`define RGBFC_ADDR_MON       8'h01
`define RGBFC_ADDR_CTRL      8'h02
`define RGBFC_ADDR_LVL_FIRST 8'h03
`define RGBFC_ADDR_LVL_LAST  8'h08
`define RGBFC_ADDR_SEL_FIRST 8'h09
`define RGBFC_ADDR_SEL_LAST  8'h0c
`define RGBFC_ADDR_RED_A     8'h03
`define RGBFC_ADDR_GREEN_A   8'h04
`define RGBFC_ADDR_BLUE_A    8'h05
`define RGBFC_ADDR_RED_B     8'h06
`define RGBFC_ADDR_GREEN_B   8'h07
`define RGBFC_ADDR_BLUE_B    8'h08
`define RGBFC_ADDR_SEL_0     8'h09
`define RGBFC_ADDR_SEL_1     8'h0a
`define RGBFC_ADDR_SEL_2     8'h0b
`define RGBFC_ADDR_SEL_3     8'h0c

// ----------------------------------------
// global_control fields and reset values
// ----------------------------------------
`define RGBFC_CTRL_MODE_HI   7
`define RGBFC_CTRL_MODE_LO   6
`define RGBFC_CTRL_DROP_EN   5
`define RGBFC_CTRL_TEMP_HI   4
`define RGBFC_CTRL_TEMP_LO   3
`define RGBFC_CTRL_RATE_HI   2
`define RGBFC_CTRL_RATE_LO   0
`define RGBFC_CTRL_RESET     8'h00
`define RGBFC_LVL_RESET      8'h00
`define RGBFC_SEL_RESET      8'h00

// ----------------------------------------
// monitor fields
// ----------------------------------------
`define RGBFC_MON_REV_HI     7
`define RGBFC_MON_REV_LO     6
`define RGBFC_MON_SHORT      5
`define RGBFC_MON_DROP       4
`define RGBFC_MON_TEMP       3
`define RGBFC_MON_FAULT      2

// ----------------------------------------
// current scaling
// ----------------------------------------
`define RGBFC_NIGHT_SHIFT    4
`define RGBFC_PEAK_SHIFT     2
`define RGBFC_SCALE_FULL     8'h80
`define RGBFC_SCALE_MIN      8'h20
`define RGBFC_FADE_SHIFT     8

// ----------------------------------------
// timing
// ----------------------------------------
`define RGBFC_CLK_MHZ        100
`define RGBFC_TAU_MIN_US     31250
`define RGBFC_FADE_TICK_CYC  (`RGBFC_TAU_MIN_US * `RGBFC_CLK_MHZ / (1 << `RGBFC_FADE_SHIFT))
`define RGBFC_SLOT_NS        10900
`define RGBFC_SLOT_CYC       (`RGBFC_SLOT_NS * `RGBFC_CLK_MHZ / 1000)
`define RGBFC_GAP_NS         200
`define RGBFC_GAP_CYC        ((`RGBFC_GAP_NS * `RGBFC_CLK_MHZ + 999) / 1000)
`define RGBFC_SCALE_STEP_US  100
`define RGBFC_SCALE_TICK_CYC (`RGBFC_SCALE_STEP_US * `RGBFC_CLK_MHZ)

`endif

/* design/rgbfc_pkg.sv */
package rgbfc_pkg;

  // ----------------------------------------
  // mode field codes and device states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RGBFC_MODE_OFF    = 2'h0,
    RGBFC_MODE_NIGHT  = 2'h1,
    RGBFC_MODE_NORMAL = 2'h2,
    RGBFC_MODE_RESET  = 2'h3
  } rgbfc_mode_t;

  typedef enum logic [1:0] {
    RGBFC_ST_SHUT  = 2'h0,
    RGBFC_ST_RUN   = 2'h1,
    RGBFC_ST_DRAIN = 2'h3
  } rgbfc_state_t;

endpackage

/* design/rgbfc_fade.sv */
`timescale 1ns/1ps
`include "rgbfc_regs.svh"

module rgbfc_fade (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        tick,
  input  wire logic [11:0] target,
  output logic      [11:0] level
);

  typedef struct packed {
    logic [19:0] acc;
  } rgbfc_fade_st_t;

  rgbfc_fade_st_t r;
  rgbfc_fade_st_t n;

  // ----------------------------------------
  // first-order smoothing toward the target
  // ----------------------------------------
  always_comb begin
    logic signed [20:0] diff;
    logic signed [20:0] step;
    diff = '0;
    step = '0;
    n = r;
    diff = $signed({1'b0, target, 8'h00}) - $signed({1'b0, r.acc});
    step = diff >>> `RGBFC_FADE_SHIFT;
    // the last fraction would stall short of the target, so force a unit step
    if (step == 21'sd0 && diff != 21'sd0) begin
      step = (diff > 21'sd0) ? 21'sd1 : -21'sd1;
    end
    if (tick) begin
      n.acc = 20'(r.acc + step[19:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level = r.acc[19:8];

endmodule

/* design/rgbfc_mux.sv */
`timescale 1ns/1ps
`include "rgbfc_regs.svh"

module rgbfc_mux (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [23:0][11:0] levels,
  output logic      [3:0]        com_en,
  output logic      [5:0]        sink_on,
  output logic      [5:0][13:0]  sink_code
);

  typedef struct packed {
    logic [10:0]      cnt;
    logic [1:0]       slot;
    logic [3:0]       com;
    logic [5:0]       on;
    logic [5:0][13:0] code;
  } rgbfc_mux_st_t;

  rgbfc_mux_st_t r;
  rgbfc_mux_st_t n;

  // ----------------------------------------
  // slot sequencer
  // ----------------------------------------
  always_comb begin
    logic gap;
    logic [11:0] lv;
    gap = 1'b0;
    lv = '0;
    n = r;
    if (r.cnt == 11'(`RGBFC_SLOT_CYC - 1)) begin
      n.cnt = '0;
      n.slot = 2'(r.slot + 2'h1);
    end else begin
      n.cnt = 11'(r.cnt + 11'h001);
    end
    // dead time at each slot start keeps two commons from overlapping
    gap = n.cnt < 11'(`RGBFC_GAP_CYC);
    n.com = gap ? 4'h0 : 4'(4'h1 << n.slot);
    for (int j = 0; j < 6; j++) begin
      lv = levels[n.slot * 6 + j];
      n.code[j] = {lv, 2'h0};
      n.on[j] = !gap && (lv != 12'h000);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign com_en = r.com;
  assign sink_on = r.on;
  assign sink_code = r.code;

endmodule

/* design/rgbfc_core.sv */
`timescale 1ns/1ps
`include "rgbfc_regs.svh"

module rgbfc_core #(
  parameter int        FADE_TICK_CYC  = `RGBFC_FADE_TICK_CYC,
  parameter int        SCALE_TICK_CYC = `RGBFC_SCALE_TICK_CYC,
  parameter logic [3:0] VENDOR_CODE   = 4'h5,  // arbitrary value
  parameter logic [3:0] CHIP_CODE     = 4'ha,  // arbitrary value
  parameter logic [1:0] DIE_REV       = 2'h1   // arbitrary value
) (
  input  wire logic             CORE_CLK,
  input  wire logic             SRST,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  output logic      [7:0]       REG_RDATA,
  input  wire logic [23:0]      DROPOUT_DET,
  input  wire logic [3:0]       TEMP_OVER,
  input  wire logic             SHORT_DET,
  input  wire logic             SUPPLY_FAULT,
  output logic      [3:0]       COM_EN,
  output logic      [5:0]       SINK_ON,
  output logic      [5:0][13:0] SINK_CODE,
  output logic                  SINK_BIAS_EN
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [29:0]             sync1;
    logic [29:0]             sync2;
    logic [29:0]             sync3;
    logic [29:0]             filt;
    rgbfc_pkg::rgbfc_state_t state;
    logic [7:0]              ctrl;
    logic [5:0][7:0]         lvl;
    logic [3:0][7:0]         sel;
    logic [7:0]              scale;
    logic [13:0]             scale_cnt;
    logic [13:0]             base_cnt;
    logic [6:0]              oct_cnt;
    logic                    fade_tick;
    logic [7:0]              rdata;
    logic                    bias;
  } rgbfc_core_st_t;

  rgbfc_core_st_t r;
  rgbfc_core_st_t n;

  logic [23:0][11:0] target;
  logic [23:0][11:0] levels;
  logic              all_zero;
  logic              night;
  logic [29:0]       async_in;
  logic [23:0]       drop_f;
  logic [3:0]        temp_f;
  logic              drop_act;
  logic              temp_act;
  logic [1:0]        temp_sel;
  logic [2:0]        rate;

  assign async_in = {SUPPLY_FAULT, SHORT_DET, TEMP_OVER, DROPOUT_DET};
  assign drop_f = r.filt[23:0];
  assign temp_f = r.filt[27:24];
  assign temp_sel = r.ctrl[`RGBFC_CTRL_TEMP_HI:`RGBFC_CTRL_TEMP_LO];
  assign rate = r.ctrl[`RGBFC_CTRL_RATE_HI:`RGBFC_CTRL_RATE_LO];
  assign drop_act = r.ctrl[`RGBFC_CTRL_DROP_EN] && (|drop_f);
  assign temp_act = temp_f[temp_sel];
  assign night = r.ctrl[`RGBFC_CTRL_MODE_HI:`RGBFC_CTRL_MODE_LO]
                 == rgbfc_pkg::RGBFC_MODE_NIGHT;
  assign all_zero = ~|levels;

  // ----------------------------------------
  // per-channel target and fade engine
  // ----------------------------------------
  for (genvar c = 0; c < 24; c++) begin : g_ch
    localparam int M = c / 3;
    localparam int K = c % 3;
    logic [3:0]  nib;
    logic [7:0]  lvl;
    logic [11:0] base;
    logic [19:0] prod;
    // even module sits in the upper nibble
    assign nib = (M % 2 == 0) ? r.sel[M / 2][7:4] : r.sel[M / 2][3:0];
    assign lvl = nib[2 - K] ? r.lvl[3 + K] : r.lvl[K];
    // night divides by sixteen but keeps the same fine step
    assign base = night ? {4'h0, lvl} : {lvl, 4'h0};
    assign prod = base * r.scale;
    assign target[c] = (r.state == rgbfc_pkg::RGBFC_ST_RUN && nib[3])
                       ? prod[18:7] : 12'h000;

    rgbfc_fade u_fade (
      .clk    (CORE_CLK),
      .srst   (SRST),
      .tick   (r.fade_tick),
      .target (target[c]),
      .level  (levels[c])
    );
  end

  // ----------------------------------------
  // multiplexer
  // ----------------------------------------
  rgbfc_mux u_mux (
    .clk       (CORE_CLK),
    .srst      (SRST),
    .levels    (levels),
    .com_en    (COM_EN),
    .sink_on   (SINK_ON),
    .sink_code (SINK_CODE)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [6:0] mask;
    logic       reduce;
    rgbfc_pkg::rgbfc_mode_t mode;
    mask = '0;
    reduce = 1'b0;
    mode = rgbfc_pkg::RGBFC_MODE_OFF;
    n = r;

    // ----------------------------------------
    // pin inputs: a change counts once stages two and three agree
    // ----------------------------------------
    n.sync1 = async_in;
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    n.filt = (~(r.sync2 ^ r.sync3) & r.sync3) | ((r.sync2 ^ r.sync3) & r.filt);

    // ----------------------------------------
    // fade tick: base period times 2^rate, so one tick divider serves all
    // ----------------------------------------
    n.fade_tick = 1'b0;
    if (r.base_cnt == 14'(FADE_TICK_CYC - 1)) begin
      n.base_cnt = '0;
      n.oct_cnt = 7'(r.oct_cnt + 7'h01);
      mask = 7'((8'h01 << rate) - 8'h01);
      n.fade_tick = (r.oct_cnt & mask) == 7'h00;
    end else begin
      n.base_cnt = 14'(r.base_cnt + 14'h0001);
    end

    // ----------------------------------------
    // global scale
    // ----------------------------------------
    // one step per tick keeps the dimming too slow for the eye to notice
    reduce = drop_act || temp_act;
    if (r.state == rgbfc_pkg::RGBFC_ST_SHUT) begin
      n.scale = `RGBFC_SCALE_FULL;
      n.scale_cnt = '0;
    end else if (r.scale_cnt == 14'(SCALE_TICK_CYC - 1)) begin
      n.scale_cnt = '0;
      if (reduce && r.scale > `RGBFC_SCALE_MIN) begin
        n.scale = 8'(r.scale - 8'h01);
      end else if (!reduce && r.scale < `RGBFC_SCALE_FULL) begin
        n.scale = 8'(r.scale + 8'h01);
      end
    end else begin
      n.scale_cnt = 14'(r.scale_cnt + 14'h0001);
    end

    // ----------------------------------------
    // drain finishes once every engine has reached zero
    // ----------------------------------------
    if (r.state == rgbfc_pkg::RGBFC_ST_DRAIN && all_zero) begin
      n.state = rgbfc_pkg::RGBFC_ST_SHUT;
    end

    // ----------------------------------------
    // register reads, answered one cycle later
    // ----------------------------------------
    if (REG_RD) begin
      unique case (REG_ADDR)
        `RGBFC_ADDR_ID: begin
          n.rdata = {VENDOR_CODE, CHIP_CODE};
        end
        `RGBFC_ADDR_MON: begin
          n.rdata = 8'h00;
          n.rdata[`RGBFC_MON_REV_HI:`RGBFC_MON_REV_LO] = DIE_REV;
          n.rdata[`RGBFC_MON_SHORT] = r.filt[28];
          n.rdata[`RGBFC_MON_DROP] = drop_act;
          n.rdata[`RGBFC_MON_TEMP] = temp_act;
          n.rdata[`RGBFC_MON_FAULT] = r.filt[29];
        end
        `RGBFC_ADDR_CTRL: begin
          n.rdata = r.ctrl;
        end
        `RGBFC_ADDR_RED_A: begin
          n.rdata = r.lvl[0];
        end
        `RGBFC_ADDR_GREEN_A: begin
          n.rdata = r.lvl[1];
        end
        `RGBFC_ADDR_BLUE_A: begin
          n.rdata = r.lvl[2];
        end
        `RGBFC_ADDR_RED_B: begin
          n.rdata = r.lvl[3];
        end
        `RGBFC_ADDR_GREEN_B: begin
          n.rdata = r.lvl[4];
        end
        `RGBFC_ADDR_BLUE_B: begin
          n.rdata = r.lvl[5];
        end
        `RGBFC_ADDR_SEL_0: begin
          n.rdata = r.sel[0];
        end
        `RGBFC_ADDR_SEL_1: begin
          n.rdata = r.sel[1];
        end
        `RGBFC_ADDR_SEL_2: begin
          n.rdata = r.sel[2];
        end
        `RGBFC_ADDR_SEL_3: begin
          n.rdata = r.sel[3];
        end
        default: begin
          // unmapped addresses read as zero
          n.rdata = 8'h00;
        end
      endcase
    end

    // ----------------------------------------
    // register writes work in every state, shutdown included
    // ----------------------------------------
    if (REG_WR) begin
      unique case (REG_ADDR)
        `RGBFC_ADDR_CTRL: begin
          mode = rgbfc_pkg::rgbfc_mode_t'(REG_WDATA[`RGBFC_CTRL_MODE_HI:`RGBFC_CTRL_MODE_LO]);
          unique case (mode)
            rgbfc_pkg::RGBFC_MODE_RESET: begin
              n.ctrl = `RGBFC_CTRL_RESET;
              n.lvl = {6{`RGBFC_LVL_RESET}};
              n.sel = {4{`RGBFC_SEL_RESET}};
              // lit outputs still fade out rather than snap off
              n.state = (r.state == rgbfc_pkg::RGBFC_ST_SHUT)
                        ? rgbfc_pkg::RGBFC_ST_SHUT : rgbfc_pkg::RGBFC_ST_DRAIN;
            end
            rgbfc_pkg::RGBFC_MODE_OFF: begin
              n.ctrl = REG_WDATA;
              n.state = (r.state == rgbfc_pkg::RGBFC_ST_SHUT)
                        ? rgbfc_pkg::RGBFC_ST_SHUT : rgbfc_pkg::RGBFC_ST_DRAIN;
            end
            rgbfc_pkg::RGBFC_MODE_NIGHT, rgbfc_pkg::RGBFC_MODE_NORMAL: begin
              n.ctrl = REG_WDATA;
              n.state = rgbfc_pkg::RGBFC_ST_RUN;
            end
          endcase
        end
        `RGBFC_ADDR_RED_A: begin
          n.lvl[0] = REG_WDATA;
        end
        `RGBFC_ADDR_GREEN_A: begin
          n.lvl[1] = REG_WDATA;
        end
        `RGBFC_ADDR_BLUE_A: begin
          n.lvl[2] = REG_WDATA;
        end
        `RGBFC_ADDR_RED_B: begin
          n.lvl[3] = REG_WDATA;
        end
        `RGBFC_ADDR_GREEN_B: begin
          n.lvl[4] = REG_WDATA;
        end
        `RGBFC_ADDR_BLUE_B: begin
          n.lvl[5] = REG_WDATA;
        end
        `RGBFC_ADDR_SEL_0: begin
          n.sel[0] = REG_WDATA;
        end
        `RGBFC_ADDR_SEL_1: begin
          n.sel[1] = REG_WDATA;
        end
        `RGBFC_ADDR_SEL_2: begin
          n.sel[2] = REG_WDATA;
        end
        `RGBFC_ADDR_SEL_3: begin
          n.sel[3] = REG_WDATA;
        end
        // identification and monitor are read-only, so their writes fall here
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // bias follows the state, so shutdown draws no sink current
    // ----------------------------------------
    n.bias = n.state != rgbfc_pkg::RGBFC_ST_SHUT;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      r <= '0;
      r.ctrl <= `RGBFC_CTRL_RESET;
      r.lvl <= {6{`RGBFC_LVL_RESET}};
      r.sel <= {4{`RGBFC_SEL_RESET}};
      r.scale <= `RGBFC_SCALE_FULL;
      r.state <= rgbfc_pkg::RGBFC_ST_SHUT;
    end else begin
      r <= n;
    end
  end

  assign REG_RDATA = r.rdata;
  assign SINK_BIAS_EN = r.bias;

endmodule

/* tb/rgbfc_led_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// led modules: record each channel's peak code, flag dropout above headroom
// ----------------------------------------
module rgbfc_led_model (
  input  wire logic              clk,
  input  wire logic [3:0]        com_en,
  input  wire logic [5:0]        sink_on,
  input  wire logic [5:0][13:0]  sink_code,
  input  wire logic [13:0]       headroom,
  output logic      [23:0]       dropout = '0,
  output logic      [23:0][13:0] seen = '0
);
  // a sink keeps its last verdict while its slot is off, like a held comparator
  always @(posedge clk) begin
    for (int s = 0; s < 4; s++) begin
      if (com_en[s]) begin
        for (int j = 0; j < 6; j++) begin
          seen[6*s+j]    <= sink_on[j] ? sink_code[j] : 14'h0;
          dropout[6*s+j] <= sink_on[j] && (sink_code[j] > headroom);
        end
      end
    end
  end
endmodule

/* tb/rgbfc_core_assertions.sv */
`timescale 1ns/1ps

module rgbfc_chk #(
  parameter logic [3:0] VENDOR_CODE = 4'h5,
  parameter logic [3:0] CHIP_CODE   = 4'ha,
  parameter logic [1:0] DIE_REV     = 2'h1
) (
  input wire logic             CORE_CLK,
  input wire logic             SRST,
  input wire logic             REG_WR,
  input wire logic             REG_RD,
  input wire logic [7:0]       REG_ADDR,
  input wire logic [7:0]       REG_WDATA,
  input wire logic [7:0]       REG_RDATA,
  input wire logic [3:0]       COM_EN,
  input wire logic [5:0]       SINK_ON,
  input wire logic [5:0][13:0] SINK_CODE,
  input wire logic             SINK_BIAS_EN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // ----------------------------------------
  // slot timing helpers
  // ----------------------------------------
  logic [10:0] run_r;
  logic [10:0] gap_r;
  logic [3:0]  last_r;
  logic        seen_r;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      run_r  <= 11'h0;
      gap_r  <= 11'h0;
      last_r <= 4'h0;
      seen_r <= 1'b0;
    end else begin
      run_r <= (COM_EN != 4'h0) ? run_r + 11'h1 : 11'h0;
      gap_r <= (COM_EN == 4'h0) ? gap_r + 11'h1 : 11'h0;
      if (COM_EN != 4'h0) last_r <= COM_EN;
      // the first gap after reset is not judged, its start is a design choice
      if (run_r != 11'h0 && COM_EN == 4'h0) seen_r <= 1'b1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_norm_wr;
    REG_WR && REG_ADDR == 8'h02 && REG_WDATA[7:6] == 2'h2;
  endsequence
  sequence s_rst_wr;
    REG_WR && REG_ADDR == 8'h02 && REG_WDATA[7:6] == 2'h3;
  endsequence
  sequence s_ctrl_rd;
    REG_RD && !REG_WR && REG_ADDR == 8'h02;
  endsequence
  property p_run;
    $fell(|COM_EN) |-> run_r == 11'h42e;
  endproperty
  property p_gap;
    $rose(|COM_EN) && seen_r && SINK_BIAS_EN |-> gap_r == 11'h014;
  endproperty
  property p_order;
    $rose(|COM_EN) && seen_r |-> COM_EN == {last_r[2:0], last_r[3]};
  endproperty
  property p_code;
    SINK_ON[0] |-> SINK_CODE[0] != 14'h0 && SINK_CODE[0][1:0] == 2'h0;
  endproperty
  property p_shut;
    !SINK_BIAS_EN |-> SINK_ON == 6'h0;
  endproperty
  property p_drain;
    $fell(SINK_BIAS_EN) |-> SINK_CODE == '0 && SINK_ON == 6'h0;
  endproperty
  property p_id;
    REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == {VENDOR_CODE, CHIP_CODE};
  endproperty
  property p_mon;
    REG_RD && REG_ADDR == 8'h01 |=> REG_RDATA[7:6] == DIE_REV && REG_RDATA[1:0] == 2'h0;
  endproperty
  property p_norm;
    s_norm_wr |=> SINK_BIAS_EN;
  endproperty
  property p_reg_reset;
    s_rst_wr ##1 !REG_WR ##1 s_ctrl_rd |=> REG_RDATA == 8'h00;
  endproperty
  a_run: assert property (p_run) else $error("slot length wrong");
  a_gap: assert property (p_gap) else $error("slot gap wrong");
  a_order: assert property (p_order) else $error("slot order wrong");
  a_code: assert property (p_code) else $error("sink code not a peak code");
  a_shut: assert property (p_shut) else $error("sink on in shutdown");
  a_drain: assert property (p_drain) else $error("shutdown before zero");
  a_id: assert property (p_id) else $error("id read wrong");
  a_mon: assert property (p_mon) else $error("monitor fixed bits wrong");
  a_norm: assert property (p_norm) else $error("normal mode not entered");
  a_reg_reset: assert property (p_reg_reset) else $error("control not cleared");
endmodule

bind rgbfc_core rgbfc_chk #(.VENDOR_CODE(VENDOR_CODE), .CHIP_CODE(CHIP_CODE),
  .DIE_REV(DIE_REV)) u_chk (.CORE_CLK, .SRST, .REG_WR, .REG_RD, .REG_ADDR,
  .REG_WDATA, .REG_RDATA, .COM_EN, .SINK_ON, .SINK_CODE, .SINK_BIAS_EN);

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "rgbfc_regs.svh"

module testbench;
  localparam int         FRAME = `RGBFC_SLOT_CYC * 4;
  localparam logic [7:0] ID    = 8'h3c;  // arbitrary value
  localparam logic [1:0] DIE   = 2'h2;   // arbitrary value
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              short_det = 1'b0;
  logic              supply_fault = 1'b0;
  logic              rd_seen = 1'b0;
  logic        [7:0] reg_addr = 8'h00;
  logic        [7:0] reg_wdata = 8'h00;
  logic        [7:0] reg_rdata;
  logic        [3:0] temp_over = 4'h0;
  logic        [3:0] com_en;
  logic        [5:0] sink_on;
  logic  [5:0][13:0] sink_code;
  logic              bias_en;
  logic       [13:0] headroom = 14'h3fff;
  logic       [23:0] dropout;
  logic [23:0][13:0] seen;
  logic       [15:0] lfsr;
  logic        [7:0] lvl [6];
  logic        [7:0] sel [4];
  logic        [7:0] rd_q [$];
  int                bad_count = 0;
  int                check_count = 0;

  rgbfc_core #(.FADE_TICK_CYC(4), .SCALE_TICK_CYC(8), .VENDOR_CODE(ID[7:4]),
    .CHIP_CODE(ID[3:0]), .DIE_REV(DIE)) dut (.CORE_CLK(clk), .SRST(srst),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .DROPOUT_DET(dropout), .TEMP_OVER(temp_over),
    .SHORT_DET(short_det), .SUPPLY_FAULT(supply_fault), .COM_EN(com_en),
    .SINK_ON(sink_on), .SINK_CODE(sink_code), .SINK_BIAS_EN(bias_en));
  rgbfc_led_model leds (.clk(clk), .com_en(com_en), .sink_on(sink_on),
    .sink_code(sink_code), .headroom(headroom), .dropout(dropout), .seen(seen));

  initial begin
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] mon(input bit s, d, t, f);
    return {DIE, s, d, t, f, 2'h0};
  endfunction
  // upper nibble drives the even module; bit 2-c picks colour b for colour c
  function automatic logic [13:0] exp_code(input int ch, input bit night);
    logic [3:0] nib;
    logic [7:0] v;
    nib = (ch / 3) % 2 ? sel[ch / 6][3:0] : sel[ch / 6][7:4];
    v = nib[3] ? lvl[nib[2 - ch % 3] ? ch % 3 + 3 : ch % 3] : 8'h00;
    return night ? {4'h0, v, 2'h0} : {v, 6'h00};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_val(input logic [13:0] got, exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    rd_q.push_back(e);
    @(negedge clk);
    reg_rd = 1'b0;
  endtask
  // polls a frame at a time for up to eight frames, so a slow ramp costs cycles; a ramp slower than that fails
  task automatic settle(input bit night);
    bit ok;
    for (int n = 0; n < 8; n++) begin
      repeat (FRAME) @(posedge clk);
      ok = 1'b1;
      for (int c = 0; c < 24; c++) if (seen[c] !== exp_code(c, night)) ok = 1'b0;
      if (ok) break;
    end
    for (int c = 0; c < 24; c++) cmp_val(seen[c], exp_code(c, night));
    if (!ok) final_report();
  endtask
  task automatic wait_shut();
    int n;
    for (n = 0; n < 40000 && bias_en !== 1'b0; n++) @(posedge clk);
    if (n == 40000) begin
      bad_count++;
      $display("CHECK FAILED %0t shutdown not reached", $time);
      final_report();
    end
  endtask
  // ----------------------------------------
  // read result checker
  // ----------------------------------------
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) begin
    if (rd_seen && rd_q.size() > 0) cmp_val({6'h0, reg_rdata}, {6'h0, rd_q.pop_front()});
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    lfsr = 16'hb866;
    repeat (20) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    wr(8'h00, 8'hff);
    rd(8'h00, ID);
    rd(8'h02, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h01, mon(0, 0, 0, 0));
    for (int a = 3; a < 13; a++) begin
      lfsr = lfsr_next(lfsr);
      if (a < 9) lvl[a - 3] = lfsr[7:0];
      else sel[a - 9] = (a == 9) ? 8'h8f : lfsr[15:8];
      wr(a[7:0], a < 9 ? lvl[a - 3] : sel[a - 9]);
    end
    for (int a = 3; a < 13; a++) rd(a[7:0], a < 9 ? lvl[a - 3] : sel[a - 9]);
    repeat (FRAME) @(posedge clk);
    cmp_val({13'h0, bias_en}, 14'h0);
    for (int c = 0; c < 24; c++) cmp_val(seen[c], 14'h0);
    wr(8'h02, 8'h80);
    settle(0);
    lvl[0] = ~lvl[0];
    wr(8'h03, lvl[0]);
    wr(8'h02, 8'h83);
    repeat (300) @(posedge clk);
    wr(8'h02, 8'h80);
    settle(0);
    wr(8'h02, 8'h40);
    settle(1);
    wr(8'h02, 8'h00);
    wait_shut();
    // each slot is only refreshed on its own visit, so let a whole frame pass
    repeat (FRAME) @(posedge clk);
    for (int c = 0; c < 24; c++) cmp_val(seen[c], 14'h0);
    headroom = 14'h0;
    wr(8'h02, 8'h80);
    repeat (2000) @(posedge clk);
    rd(8'h01, mon(0, 0, 0, 0));
    wr(8'h02, 8'ha0);
    repeat (2000) @(posedge clk);
    rd(8'h01, mon(0, 1, 0, 0));
    headroom = 14'h3fff;
    repeat (3000) @(posedge clk);
    rd(8'h01, mon(0, 0, 0, 0));
    temp_over = 4'hb;
    wr(8'h02, 8'h90);
    repeat (2000) @(posedge clk);
    rd(8'h01, mon(0, 0, 0, 0));
    temp_over = 4'h4;
    short_det = 1'b1;
    supply_fault = 1'b1;
    repeat (2000) @(posedge clk);
    rd(8'h01, mon(1, 0, 1, 1));
    short_det = 1'b0;
    supply_fault = 1'b0;
    wr(8'h02, 8'h00);
    wait_shut();
    repeat (20) @(posedge clk);
    rd(8'h01, mon(0, 0, 0, 0));
    wr(8'h02, 8'hc0);
    rd(8'h02, 8'h00);
    for (int a = 3; a < 13; a++) rd(a[7:0], 8'h00);
    final_report();
  end
endmodule
